/* File: hw/dqg_ctrl.sv */
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
module dqg_ctrl (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        int_pin,
  input  wire logic        eq_strap_pin,
  input  wire logic        pin0_in,
  output logic             pin0_out,
  output logic             pin0_oe,
  input  wire logic        pin1_in,
  output logic             pin1_out,
  output logic             pin1_oe,
  input  wire logic        decode_error,
  input  wire logic        prbs_active,
  output logic             conversion_address_suppress,
  output logic      [1:0]  eq_highpass_select,
  output logic             hf_boost_off,
  output logic      [3:0]  eq_gain_select,
  output logic             stagger_off,
  output logic             remote_irq_out,
  output logic      [7:0]  decode_fault_count,
  output logic             decode_fault_alert,
  output logic             irq
);
  function automatic logic idx_hit(input logic [7:0] idx, input logic [7:0] want);
    idx_hit = (idx == want);
  endfunction

  logic [dqg_pkg::NUM_SYNC-1:0] sync1_reg;
  logic [dqg_pkg::NUM_SYNC-1:0] sync2_reg;
  logic [dqg_pkg::NUM_SYNC-1:0] sync3_reg;
  logic [dqg_pkg::NUM_SYNC-1:0] sync_in;
  logic [1:0]                   strap_cnt_reg;
  logic                         strap_done_reg;
  logic                         addr_sup_reg;
  logic [1:0]                   hpf_reg;
  logic                         hf_off_reg;
  logic [3:0]                   gain_reg;
  logic                         stagger_reg;
  logic                         auto_clr_reg;
  logic                         gate_reg;
  logic                         drive1_reg;
  logic                         drive0_reg;
  logic [dqg_pkg::NUM_EV-1:0]   stat_reg;
  logic [dqg_pkg::NUM_EV-1:0]   mask_reg;
  logic                         wr_pend_reg;
  logic                         rd_pend_reg;
  logic [7:0]                   idx_reg;
  logic [31:0]                  hrdata_reg;
  logic                         hreadyout_reg;
  logic                         remote_irq_reg;
  logic                         alert_reg;
  logic                         irq_reg;
  logic                         pin_out1_reg;
  logic                         pin_out0_reg;
  logic                         pin_oe_reg;

  assign sync_in[dqg_pkg::SYNC_INT]   = int_pin;
  assign sync_in[dqg_pkg::SYNC_PIN0]  = pin0_in;
  assign sync_in[dqg_pkg::SYNC_PIN1]  = pin1_in;
  assign sync_in[dqg_pkg::SYNC_STRAP] = eq_strap_pin;

  // pins are asynchronous; the third stage only serves edge detection
  genvar g;
  generate
    for (g = 0; g < dqg_pkg::NUM_SYNC; g++) begin : g_sync
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
          sync3_reg[g] <= 1'b0;
        end else begin
          sync1_reg[g] <= sync_in[g];
          sync2_reg[g] <= sync1_reg[g];
          sync3_reg[g] <= sync2_reg[g];
        end
      end
    end
  endgenerate

  wire int_lvl  = sync2_reg[dqg_pkg::SYNC_INT];
  wire pin0_lvl = sync2_reg[dqg_pkg::SYNC_PIN0];
  wire pin1_lvl = sync2_reg[dqg_pkg::SYNC_PIN1];

  // bus decode
  wire       accept    = hsel && htrans[1] && hready;
  wire [7:0] addr_idx  = haddr[9:2];
  wire       wr_eq     = wr_pend_reg && idx_hit(idx_reg, dqg_pkg::IDX_EQ_CFG);
  wire       wr_pin    = wr_pend_reg && idx_hit(idx_reg, dqg_pkg::IDX_PIN_CTRL);
  wire       wr_mask   = wr_pend_reg && idx_hit(idx_reg, dqg_pkg::IDX_IRQ_MASK);
  wire       rd_stat   = rd_pend_reg && idx_hit(idx_reg, dqg_pkg::IDX_IRQ_STAT);
  wire [3:0] wr_gain   = hwdata[dqg_pkg::GAIN_LSB +: 4];
  wire       gain_ok   = wr_gain[3:2] != dqg_pkg::GAIN_FORBIDDEN;
  wire       strap_now = !strap_done_reg && strap_cnt_reg == dqg_pkg::STRAP_WAIT;

  wire [7:0] eq_view  = {addr_sup_reg, hpf_reg, hf_off_reg, gain_reg};
  wire [7:0] pin_view = {stagger_reg, auto_clr_reg, gate_reg, int_lvl,
                         drive1_reg, pin1_lvl, drive0_reg, pin0_lvl};
  wire [7:0] rd_byte  =
    idx_hit(idx_reg, dqg_pkg::IDX_EQ_CFG)    ? eq_view :
    idx_hit(idx_reg, dqg_pkg::IDX_PIN_CTRL)  ? pin_view :
    idx_hit(idx_reg, dqg_pkg::IDX_FAULT_CNT) ? decode_fault_count :
    idx_hit(idx_reg, dqg_pkg::IDX_IRQ_STAT)  ? {4'h0, stat_reg} :
    idx_hit(idx_reg, dqg_pkg::IDX_IRQ_MASK)  ? {4'h0, mask_reg} : 8'h00;

  // error counter held cleared by auto clear or prbs mode
  wire counter_hold = auto_clr_reg || prbs_active;

  dqg_err_counter u_err_counter (
    .mclk      (mclk),
    .resetn    (resetn),
    .err_pulse (decode_error),
    .hold_zero (counter_hold),
    .count     (decode_fault_count)
  );

  // events: pin level changes and counted decode faults
  // sync stages leave reset low, so edges stay masked until they hold real levels;
  // a genuine pin change in the first cycle after reset is lost
  wire [dqg_pkg::NUM_SYNC-1:0] sync_edge = strap_done_reg ? (sync2_reg ^ sync3_reg) : '0;
  wire [dqg_pkg::NUM_EV-1:0] ev;
  assign ev[dqg_pkg::EV_INT]   = sync_edge[dqg_pkg::SYNC_INT];
  assign ev[dqg_pkg::EV_PIN0]  = sync_edge[dqg_pkg::SYNC_PIN0];
  assign ev[dqg_pkg::EV_PIN1]  = sync_edge[dqg_pkg::SYNC_PIN1];
  assign ev[dqg_pkg::EV_FAULT] = decode_error && !counter_hold;

  // read clear loses against a new event in the same cycle
  wire [dqg_pkg::NUM_EV-1:0] stat_next = (rd_stat ? '0 : stat_reg) | ev;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_reg   <= 1'b0;
      rd_pend_reg   <= 1'b0;
      idx_reg       <= 8'h00;
      hrdata_reg    <= 32'h0000_0000;
      hreadyout_reg <= 1'b1;
    end else begin
      wr_pend_reg   <= accept && hwrite;
      rd_pend_reg   <= accept && !hwrite;
      hreadyout_reg <= !(accept && !hwrite);
      if (accept) begin
        idx_reg <= addr_idx;
      end
      // one wait state lets a write just ahead land before the read is sampled
      if (rd_pend_reg) begin
        hrdata_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      strap_cnt_reg  <= 2'h0;
      strap_done_reg <= 1'b0;
    end else begin
      if (!strap_done_reg) begin
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
      end
      if (strap_now) begin
        strap_done_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      addr_sup_reg <= dqg_pkg::RST_ADDR_SUPPRESS;
      hpf_reg      <= dqg_pkg::RST_HPF;
      hf_off_reg   <= dqg_pkg::RST_HF_OFF;
      gain_reg     <= dqg_pkg::GAIN_STRAP_LOW;
    end else if (wr_eq) begin
      addr_sup_reg <= hwdata[dqg_pkg::BIT_ADDR_SUPPRESS];
      hpf_reg      <= hwdata[dqg_pkg::HPF_LSB +: 2];
      hf_off_reg   <= hwdata[dqg_pkg::BIT_HF_OFF];
      if (gain_ok) begin
        gain_reg <= wr_gain;
      end
    end else if (strap_now) begin
      gain_reg <= sync2_reg[dqg_pkg::SYNC_STRAP] ? dqg_pkg::GAIN_STRAP_HIGH :
                  dqg_pkg::GAIN_STRAP_LOW;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stagger_reg  <= dqg_pkg::RST_STAGGER_OFF;
      auto_clr_reg <= dqg_pkg::RST_AUTO_CLR;
      gate_reg     <= dqg_pkg::RST_IRQ_GATE;
      drive1_reg   <= dqg_pkg::RST_PIN_DRIVE;
      drive0_reg   <= dqg_pkg::RST_PIN_DRIVE;
    end else if (wr_pin) begin
      stagger_reg  <= hwdata[dqg_pkg::BIT_STAGGER_OFF];
      auto_clr_reg <= hwdata[dqg_pkg::BIT_AUTO_CLR];
      gate_reg     <= hwdata[dqg_pkg::BIT_IRQ_GATE];
      drive1_reg   <= hwdata[dqg_pkg::BIT_PIN1_DRIVE];
      drive0_reg   <= hwdata[dqg_pkg::BIT_PIN0_DRIVE];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stat_reg       <= '0;
      mask_reg       <= dqg_pkg::RST_IRQ_MASK;
      irq_reg        <= 1'b0;
      remote_irq_reg <= 1'b0;
      alert_reg      <= 1'b0;
      pin_out1_reg   <= dqg_pkg::RST_PIN_DRIVE;
      pin_out0_reg   <= dqg_pkg::RST_PIN_DRIVE;
      pin_oe_reg     <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      if (wr_mask) begin
        mask_reg <= hwdata[dqg_pkg::NUM_EV-1:0];
      end
      irq_reg        <= |(stat_next & mask_reg);
      remote_irq_reg <= gate_reg && int_lvl;
      alert_reg      <= !counter_hold && decode_fault_count != 8'h00;
      pin_out1_reg   <= drive1_reg;
      pin_out0_reg   <= drive0_reg;
      pin_oe_reg     <= 1'b1;
    end
  end

  assign hrdata                      = hrdata_reg;
  assign hreadyout                   = hreadyout_reg;
  assign hresp                       = 1'b0;
  assign conversion_address_suppress = addr_sup_reg;
  assign eq_highpass_select          = hpf_reg;
  assign hf_boost_off                = hf_off_reg;
  assign eq_gain_select              = gain_reg;
  assign stagger_off                 = stagger_reg;
  assign remote_irq_out              = remote_irq_reg;
  assign decode_fault_alert          = alert_reg;
  assign irq                         = irq_reg;
  assign pin1_out                    = pin_out1_reg;
  assign pin0_out                    = pin_out0_reg;
  assign pin1_oe                     = pin_oe_reg;
  assign pin0_oe                     = pin_oe_reg;

  property p_addr_sup;
    @(posedge mclk) disable iff (!resetn)
    wr_eq |=> conversion_address_suppress == $past(hwdata[7]);
  endproperty
  a_addr_sup: assert property (p_addr_sup) else $error("address suppress not written");

  property p_hpf;
    @(posedge mclk) disable iff (!resetn)
    wr_eq |=> eq_highpass_select == $past(hwdata[6:5]) && hf_boost_off == $past(hwdata[4]);
  endproperty
  a_hpf: assert property (p_hpf) else $error("highpass or boost off not written");

  property p_gain_legal;
    @(posedge mclk) disable iff (!resetn)
    eq_gain_select[3:2] != 2'b11 and (wr_eq && hwdata[3:2] == 2'b11 |=> $stable(eq_gain_select));
  endproperty
  a_gain_legal: assert property (p_gain_legal) else $error("forbidden gain code");

  property p_strap;
    @(posedge mclk) disable iff (!resetn)
    $rose(strap_done_reg) |-> eq_gain_select == ($past(sync2_reg[3]) ? 4'h4 : 4'h9);
  endproperty
  a_strap: assert property (p_strap) else $error("strap gain not loaded");

  property p_auto_clr;
    @(posedge mclk) disable iff (!resetn)
    auto_clr_reg ##1 auto_clr_reg |-> decode_fault_count == 8'h00 ##1 !decode_fault_alert;
  endproperty
  a_auto_clr: assert property (p_auto_clr) else $error("errors not auto cleared");

  property p_gate;
    @(posedge mclk) disable iff (!resetn)
    !gate_reg |=> !remote_irq_out;
  endproperty
  a_gate: assert property (p_gate) else $error("interrupt forwarded while gated");

  property p_levels;
    @(posedge mclk) disable iff (!resetn)
    rd_pend_reg && idx_hit(idx_reg, 8'h06) |=>
      hrdata[4] == $past(int_lvl) && hrdata[2] == $past(pin1_lvl) &&
      hrdata[0] == $past(pin0_lvl) && hreadyout;
  endproperty
  a_levels: assert property (p_levels) else $error("pin level read back wrong");

  property p_pin1;
    @(posedge mclk) disable iff (!resetn)
    wr_pin |-> ##2 pin1_out == $past(hwdata[3], 2) && pin1_oe;
  endproperty
  a_pin1: assert property (p_pin1) else $error("pin1 drive wrong");

  property p_pin0;
    @(posedge mclk) disable iff (!resetn)
    wr_pin |-> ##2 pin0_out == $past(hwdata[1], 2) && pin0_oe;
  endproperty
  a_pin0: assert property (p_pin0) else $error("pin0 drive wrong");

  property p_prbs;
    @(posedge mclk) disable iff (!resetn)
    prbs_active |=> decode_fault_count == 8'h00;
  endproperty
  a_prbs: assert property (p_prbs) else $error("fault count moved during prbs");
endmodule

/* File: hw/dqg_pkg.sv */
package dqg_pkg;
  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_EQ_CFG    = 8'h05;
  localparam logic [7:0] IDX_PIN_CTRL  = 8'h06;
  localparam logic [7:0] IDX_FAULT_CNT = 8'h0d;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'h10;
  localparam logic [7:0] IDX_IRQ_MASK  = 8'h11;

  // equalizer_and_i2c_config fields
  localparam int BIT_ADDR_SUPPRESS = 7;
  localparam int HPF_LSB           = 5;
  localparam int BIT_HF_OFF        = 4;
  localparam int GAIN_LSB          = 0;

  // output_interrupt_pin_control fields
  localparam int BIT_STAGGER_OFF = 7;
  localparam int BIT_AUTO_CLR    = 6;
  localparam int BIT_IRQ_GATE    = 5;
  localparam int BIT_INT_LEVEL   = 4;
  localparam int BIT_PIN1_DRIVE  = 3;
  localparam int BIT_PIN1_LEVEL  = 2;
  localparam int BIT_PIN0_DRIVE  = 1;
  localparam int BIT_PIN0_LEVEL  = 0;

  // reset values, strap gains and the forbidden gain code
  localparam logic       RST_ADDR_SUPPRESS = 1'b0;
  localparam logic [1:0] RST_HPF           = 2'h1;
  localparam logic       RST_HF_OFF        = 1'b0;
  localparam logic [3:0] GAIN_STRAP_HIGH   = 4'h4;
  localparam logic [3:0] GAIN_STRAP_LOW    = 4'h9;
  localparam logic [1:0] GAIN_FORBIDDEN    = 2'h3;
  localparam logic       RST_STAGGER_OFF   = 1'b0;
  localparam logic       RST_AUTO_CLR      = 1'b0;
  localparam logic       RST_IRQ_GATE      = 1'b0;
  localparam logic       RST_PIN_DRIVE     = 1'b1;
  localparam logic [3:0] RST_IRQ_MASK      = 4'h0;

  // interrupt event bits
  localparam int EV_INT   = 0;
  localparam int EV_PIN0  = 1;
  localparam int EV_PIN1  = 2;
  localparam int EV_FAULT = 3;
  localparam int NUM_EV   = 4;

  // synchronised pin inputs
  localparam int SYNC_INT   = 0;
  localparam int SYNC_PIN0  = 1;
  localparam int SYNC_PIN1  = 2;
  localparam int SYNC_STRAP = 3;
  localparam int NUM_SYNC   = 4;

  // edges after reset release before the strap level is settled
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  localparam int         FAULT_W   = 8;
  localparam logic [7:0] FAULT_MAX = 8'hff;
endpackage

/* File: hw/dqg_err_counter.sv */
`timescale 1ns/100ps
module dqg_err_counter (
  input  wire logic                         mclk,
  input  wire logic                         resetn,
  input  wire logic                         err_pulse,
  input  wire logic                         hold_zero,
  output logic      [dqg_pkg::FAULT_W-1:0]  count
);
  logic [dqg_pkg::FAULT_W-1:0] count_reg;
  logic [dqg_pkg::FAULT_W-1:0] count_next;

  // saturates so a long burst never wraps back to a small value
  assign count_next = hold_zero ? '0 :
                      (err_pulse && count_reg != dqg_pkg::FAULT_MAX) ?
                      count_reg + 8'h01 : count_reg;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;
endmodule

/* File: testbench/dqg_ser_model.sv */
`timescale 1ns/100ps
// serializer side of the link: counts forwarded interrupt rises.
// the forwarded line is a level, so only its rising edges are counted.
module dqg_ser_model (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       remote_irq,
  output logic      [7:0] irq_rises
);
  logic irq_prev;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_prev  <= 1'b0;
      irq_rises <= 8'h00;
    end else begin
      irq_prev <= remote_irq;
      if (remote_irq && !irq_prev) begin
        irq_rises <= irq_rises + 8'h01;
      end
    end
  end
endmodule

/* File: testbench/deser_eq_gpio_control_bench.sv */
`timescale 1ns/100ps
module deser_eq_gpio_control_bench;
  logic        mclk, resetn, hsel, hwrite, hreadyout, hresp, int_pin, eq_strap_pin;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, eq_highpass_select;
  logic [2:0]  hsize;
  logic        pin0_in, pin0_out, pin0_oe, pin1_in, pin1_out, pin1_oe;
  logic        decode_error, prbs_active, conversion_address_suppress, hf_boost_off;
  logic [3:0]  eq_gain_select;
  logic        stagger_off, remote_irq_out, decode_fault_alert, irq;
  logic [7:0]  decode_fault_count, irq_rises;
  int          fail_count, cmp_count;
  localparam logic [31:0] A_EQ   = {22'h0, dqg_pkg::IDX_EQ_CFG, 2'b00};
  localparam logic [31:0] A_PIN  = {22'h0, dqg_pkg::IDX_PIN_CTRL, 2'b00};
  localparam logic [31:0] A_CNT  = {22'h0, dqg_pkg::IDX_FAULT_CNT, 2'b00};
  localparam logic [31:0] A_STAT = {22'h0, dqg_pkg::IDX_IRQ_STAT, 2'b00};
  localparam logic [31:0] A_MASK = {22'h0, dqg_pkg::IDX_IRQ_MASK, 2'b00};

  // push-pull pads with a pull-up while the drivers are off in reset
  assign pin0_in = pin0_oe ? pin0_out : 1'b1;
  assign pin1_in = pin1_oe ? pin1_out : 1'b1;

  dqg_ctrl u_dqg_ctrl (
    .mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .int_pin(int_pin),
    .eq_strap_pin(eq_strap_pin), .pin0_in(pin0_in), .pin0_out(pin0_out),
    .pin0_oe(pin0_oe), .pin1_in(pin1_in), .pin1_out(pin1_out), .pin1_oe(pin1_oe),
    .decode_error(decode_error), .prbs_active(prbs_active),
    .conversion_address_suppress(conversion_address_suppress),
    .eq_highpass_select(eq_highpass_select), .hf_boost_off(hf_boost_off),
    .eq_gain_select(eq_gain_select), .stagger_off(stagger_off),
    .remote_irq_out(remote_irq_out), .decode_fault_count(decode_fault_count),
    .decode_fault_alert(decode_fault_alert), .irq(irq)
  );
  dqg_ser_model u_dqg_ser_model (
    .mclk(mclk), .resetn(resetn), .remote_irq(remote_irq_out), .irq_rises(irq_rises)
  );

  task stop_test;
    if (fail_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // ready is registered, so the value read just after the edge is the sampled one
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      stop_test();
    end
  endtask

  task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rdchk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task pulse(input int n);
    repeat (n) begin
      @(posedge mclk) decode_error <= 1'b1;
      @(posedge mclk) decode_error <= 1'b0;
    end
  endtask

  task do_reset(input logic strap);
    @(posedge mclk);
    resetn       <= 1'b0;
    eq_strap_pin <= strap;
    cyc(2);
    resetn <= 1'b1;
    cyc(4);
  endtask

  task t_reset;
    rdchk(A_STAT, 32'h00);
    rdchk(A_EQ, 32'h24);
    rdchk(A_PIN, 32'h0f);
    chk({pin1_out, pin0_out, pin1_oe, pin0_oe}, 4'hf);
    do_reset(1'b0);
    rdchk(A_EQ, 32'h29);
    chk(eq_gain_select, 4'h9);
    rdchk(A_STAT, 32'h00);
  endtask

  task t_eq;
    logic [3:0] gains [4];
    logic [7:0] v;
    gains = '{4'h0, 4'hb, 4'h5, 4'ha};
    for (int i = 0; i < 4; i++) begin
      v = {i[0], i[1:0], ~i[0], gains[i]};
      wr(A_EQ, {24'h0, v});
      cyc(2);
      chk({conversion_address_suppress, eq_highpass_select, hf_boost_off, eq_gain_select},
          v);
      rdchk(A_EQ, {24'h0, v});
    end
    wr(A_EQ, 32'h4c);
    rdchk(A_EQ, 32'h4a);
    wr(A_EQ, 32'hff);
    rdchk(A_EQ, 32'hfa);
  endtask

  task t_pins;
    wr(A_PIN, 32'h15);
    cyc(5);
    chk({pin1_out, pin0_out}, 2'b00);
    rdchk(A_PIN, 32'h00);
    wr(A_PIN, 32'h88);
    int_pin <= 1'b1;
    cyc(5);
    chk({stagger_off, pin1_out, pin0_out}, 3'b110);
    rdchk(A_PIN, 32'h9c);
    wr(A_PIN, 32'h02);
    cyc(5);
    rdchk(A_PIN, 32'h13);
    int_pin <= 1'b0;
    wr(A_PIN, 32'h0a);
  endtask

  task t_gate;
    logic [7:0] r0;
    r0 = irq_rises;
    int_pin <= 1'b1;
    cyc(5);
    chk(remote_irq_out, 1'b0);
    wr(A_PIN, 32'h2a);
    cyc(3);
    chk({remote_irq_out, irq_rises}, {1'b1, r0 + 8'h01});
    int_pin <= 1'b0;
    cyc(5);
    chk(remote_irq_out, 1'b0);
    wr(A_PIN, 32'h0a);
  endtask

  task t_err;
    pulse(3);
    cyc(2);
    chk({decode_fault_alert, decode_fault_count}, 9'h103);
    rdchk(A_CNT, 32'h03);
    prbs_active <= 1'b1;
    cyc(2);
    chk(decode_fault_count, 8'h00);
    pulse(2);
    cyc(2);
    rdchk(A_CNT, 32'h00);
    prbs_active <= 1'b0;
    pulse(2);
    cyc(2);
    chk(decode_fault_count, 8'h02);
    wr(A_PIN, 32'h4a);
    cyc(2);
    pulse(1);
    cyc(2);
    chk({decode_fault_alert, decode_fault_count}, 9'h000);
    wr(A_PIN, 32'h0a);
    pulse(1);
    cyc(2);
    chk(decode_fault_count, 8'h01);
  endtask

  task t_irq;
    bus(1'b0, A_STAT, 32'h0);
    wr(A_MASK, 32'h01);
    cyc(2);
    chk(irq, 1'b0);
    int_pin <= 1'b1;
    cyc(6);
    chk(irq, 1'b1);
    bus(1'b0, A_STAT, 32'h0);
    chk(rd & 32'h1, 32'h1);
    cyc(2);
    chk(irq, 1'b0);
    pulse(1);
    cyc(3);
    chk(irq, 1'b0);
    rdchk(A_STAT, 32'h08);
    wr(A_MASK, 32'h08);
    pulse(1);
    cyc(3);
    chk(irq, 1'b1);
    rdchk(A_MASK, 32'h08);
    rdchk(A_STAT, 32'h08);
    cyc(2);
    chk(irq, 1'b0);
    rdchk(32'h80, 32'h0);
    wr(32'h80, 32'hff);
    chk(hresp, 1'b0);
    rdchk(A_EQ, 32'hfa);
  endtask

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    stop_test();
  end

  initial begin
    fail_count   = 0;
    cmp_count    = 0;
    resetn       = 1'b0;
    hsel         = 1'b0;
    haddr        = 32'h0;
    htrans       = 2'b00;
    hwrite       = 1'b0;
    hsize        = 3'b010;
    hwdata       = 32'h0;
    int_pin      = 1'b0;
    eq_strap_pin = 1'b1;
    decode_error = 1'b0;
    prbs_active  = 1'b0;
    cyc(2);
    resetn <= 1'b1;
    cyc(4);
    t_reset();
    t_eq();
    t_pins();
    t_gate();
    t_err();
    t_irq();
    stop_test();
  end
endmodule
